// ---- logic/pdsb_bank.sv ----
// Secondary status and interrupt register bank of a Type-C / PD port controller.
// Assumes event strobes and the register port are synchronous to clock_in.
// Summary of operation
// - Soft-reset-failure status bit 5 sets on failure, clears on transmit commands.
// - Retry-failure status bit 4 sets on exhausted retries, clears on transmit commands.
// - Status bits 3:2 mirror the internal power request for the top enables.
// - Effective power is the larger of software enables and internal-request value.
// - Status bit 1 sets when a received packet is a soft reset.
// - Status bit 0 sets when a hard reset ordered set is received.
// - Bits 5:3 carry the toggle result code from the toggle engine.
// - Bits 2:0 flag the start-of-packet type of the last stored packet.
// - Interrupt bit 7 on VCONN over-current or over-temperature.
// - Interrupt bit 6 when toggling stops on an attach.
// - Interrupt bit 5 when automatic soft resets all failed.
// - Interrupt bit 4 when automatic retries all failed.
// - Interrupt bit 3 after a hard reset was sent.
// - Interrupt bit 2 when a sent packet got GoodCRC.
// - Interrupt bit 1 when a soft reset packet was received.
// - Interrupt bit 0 of the first register on received hard reset.
// - Second interrupt register bit 0 after sending a GoodCRC.
// - Enable makes retry failure request an automatic soft reset.
// - Mask bit at one keeps its interrupt from the host.
`timescale 1ns/100ps
module pdsb_bank (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Event strobes and levels from the PD engines
  input wire pdsb_pkg::pdsb_events_s events_in,
  input wire pdsb_pkg::pdsb_sop_e rx_sop_type_in,
  input wire logic [2:0] toggle_result_code_in,
  input wire logic [1:0] internal_power_request_in,
  input wire logic [3:0] power_enables_in,
  input wire logic auto_soft_reset_enable_in,
  // Outputs to the PD engines and host
  output logic [3:0] effective_power_out,
  output logic auto_soft_reset_req_out,
  output logic irq_pending_out
);
  import pdsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic soft_fail_q;
  logic retry_fail_q;
  logic soft_rx_q;
  logic hard_rx_q;
  logic [2:0] sop_flags_q;
  logic [7:0] event_irq_q;
  logic ack_irq_q;
  logic [7:0] mask_a_q;
  logic mask_b_q;
  logic [7:0] rdata_q;
  logic [3:0] power_q;
  logic auto_req_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  wire rd_event_irq = reg_rd_in && hit(reg_addr_in, PDSB_EVENT_IRQ_OFS);
  wire rd_ack_irq = reg_rd_in && hit(reg_addr_in, PDSB_ACK_IRQ_OFS);
  wire wr_mask_a = reg_wr_in && hit(reg_addr_in, PDSB_MASK_A_OFS);
  wire wr_mask_b = reg_wr_in && hit(reg_addr_in, PDSB_MASK_B_OFS);

  // Any transmit command clears the two failure flags
  wire tx_cmd = events_in.tx_start_cmd || events_in.transmitter_on_cmd ||
                events_in.hard_reset_send_cmd;

  // Power state: compare software enables with internal-request form
  wire [3:0] internal_form = {internal_power_request_in, power_enables_in[1:0]};
  wire [3:0] power_d = (power_enables_in > internal_form) ?
                       power_enables_in : internal_form;

  // Start-of-packet flags for the packet just stored
  wire [2:0] sop_d = {rx_sop_type_in == PDSB_SOP_DPRIME_DBG,
                      rx_sop_type_in == PDSB_SOP_PRIME_DBG,
                      rx_sop_type_in == PDSB_SOP_PLAIN};

  // Event interrupt sources
  logic [7:0] event_set;
  always_comb begin
    event_set = 8'h00;
    event_set[PDSB_IRQ_OCP_TEMP] = events_in.overcurrent || events_in.overtemp;
    event_set[PDSB_IRQ_TOGGLE] = events_in.toggle_finished;
    event_set[PDSB_IRQ_SOFT_FAIL] = events_in.soft_reset_failed;
    event_set[PDSB_IRQ_RETRY_FAIL] = events_in.retries_exhausted;
    event_set[PDSB_IRQ_HARD_SENT] = events_in.hard_reset_sent;
    event_set[PDSB_IRQ_ACKED] = events_in.packet_acked;
    event_set[PDSB_IRQ_SOFT_RX] = events_in.soft_reset_received;
    event_set[PDSB_IRQ_HARD_RX] = events_in.hard_reset_received;
  end

  // Read-clear next values; a same-cycle event wins over the clear
  wire [7:0] event_irq_d = (rd_event_irq ? 8'h00 : event_irq_q) | event_set;
  wire ack_irq_d = (rd_ack_irq ? 1'b0 : ack_irq_q) || events_in.ack_sent;

  // Status register images, reserved bits zero
  wire [7:0] status_a = {2'b00, soft_fail_q, retry_fail_q, internal_power_request_in,
                         soft_rx_q, hard_rx_q};
  wire [7:0] toggle_sop = {2'b00, toggle_result_code_in, sop_flags_q};

  // Read data select
  logic [7:0] rdata_d;
  always_comb begin
    case (reg_addr_in)
      PDSB_MASK_A_OFS: rdata_d = mask_a_q;
      PDSB_MASK_B_OFS: rdata_d = {7'h00, mask_b_q};
      PDSB_STATUS_A_OFS: rdata_d = status_a;
      PDSB_TOGGLE_SOP_OFS: rdata_d = toggle_sop;
      PDSB_EVENT_IRQ_OFS: rdata_d = event_irq_q;
      PDSB_ACK_IRQ_OFS: rdata_d = {7'h00, ack_irq_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // Unmasked pending interrupts reach the host line
  wire irq_d = |(event_irq_d & ~mask_a_q) || (ack_irq_d && !mask_b_q);

  ////////////////////////////////////////////////////////////////////////////
  // Failure status flags: failure sets, transmit command clears, set wins
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      soft_fail_q <= 1'b0;
      retry_fail_q <= 1'b0;
    end else begin
      soft_fail_q <= events_in.soft_reset_failed || (soft_fail_q && !tx_cmd);
      retry_fail_q <= events_in.retries_exhausted || (retry_fail_q && !tx_cmd);
    end
  end

  // Received reset status flags, held until the next transmit command
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      soft_rx_q <= 1'b0;
      hard_rx_q <= 1'b0;
    end else begin
      soft_rx_q <= events_in.soft_reset_received || (soft_rx_q && !tx_cmd);
      hard_rx_q <= events_in.hard_reset_received || (hard_rx_q && !tx_cmd);
    end
  end

  // Start-of-packet flags update per stored packet
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      sop_flags_q <= 3'h0;
    end else if (events_in.rx_packet_stored) begin
      sop_flags_q <= sop_d;
    end
  end

  // Interrupt registers
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      event_irq_q <= PDSB_REG_RESET;
      ack_irq_q <= 1'b0;
    end else begin
      event_irq_q <= event_irq_d;
      ack_irq_q <= ack_irq_d;
    end
  end

  // Mask registers, host writable
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      mask_a_q <= PDSB_REG_RESET;
      mask_b_q <= 1'b0;
    end else begin
      if (wr_mask_a) begin
        mask_a_q <= reg_wdata_in;
      end
      if (wr_mask_b) begin
        mask_b_q <= reg_wdata_in[0];
      end
    end
  end

  // Read data, power state, auto soft reset request and interrupt line
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      rdata_q <= PDSB_REG_RESET;
      power_q <= PDSB_PWR_RESET;
      auto_req_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd_in ? rdata_d : 8'h00;
      power_q <= power_d;
      auto_req_q <= events_in.retries_exhausted && auto_soft_reset_enable_in;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_out = rdata_q;
  assign effective_power_out = power_q;
  assign auto_soft_reset_req_out = auto_req_q;
  assign irq_pending_out = irq_q;
endmodule : pdsb_bank

// ---- logic/pdsb_pkg.sv ----
// Constants, offsets and event carriers for the PD status and interrupt bank.
// Assumes a single 50 MHz clock domain shared with the register port.
package pdsb_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] PDSB_MASK_A_OFS = 8'h0E;
  localparam logic [7:0] PDSB_MASK_B_OFS = 8'h0F;
  localparam logic [7:0] PDSB_STATUS_A_OFS = 8'h3C;
  localparam logic [7:0] PDSB_TOGGLE_SOP_OFS = 8'h3D;
  localparam logic [7:0] PDSB_EVENT_IRQ_OFS = 8'h3E;
  localparam logic [7:0] PDSB_ACK_IRQ_OFS = 8'h3F;
  // Reset values
  localparam logic [7:0] PDSB_REG_RESET = 8'h00;
  localparam logic [3:0] PDSB_PWR_RESET = 4'h0;
  localparam logic [2:0] PDSB_TOGGLE_RUNNING = 3'h0;
  // Status A field positions
  localparam int PDSB_SA_SOFT_FAIL = 5;
  localparam int PDSB_SA_RETRY_FAIL = 4;
  localparam int PDSB_SA_PWR_LO = 2;
  localparam int PDSB_SA_SOFT_RX = 1;
  localparam int PDSB_SA_HARD_RX = 0;
  // Toggle/SOP field positions
  localparam int PDSB_TS_TOGGLE_LO = 3;
  localparam int PDSB_TS_DPRIME_DBG = 2;
  localparam int PDSB_TS_PRIME_DBG = 1;
  localparam int PDSB_TS_PLAIN_SOP = 0;
  // Event interrupt bit positions
  localparam int PDSB_IRQ_OCP_TEMP = 7;
  localparam int PDSB_IRQ_TOGGLE = 6;
  localparam int PDSB_IRQ_SOFT_FAIL = 5;
  localparam int PDSB_IRQ_RETRY_FAIL = 4;
  localparam int PDSB_IRQ_HARD_SENT = 3;
  localparam int PDSB_IRQ_ACKED = 2;
  localparam int PDSB_IRQ_SOFT_RX = 1;
  localparam int PDSB_IRQ_HARD_RX = 0;
  localparam int PDSB_IRQ_ACK_SENT = 0;

  // Start-of-packet types of a packet written into the receive FIFO
  typedef enum logic [1:0] {
    PDSB_SOP_PLAIN,
    PDSB_SOP_PRIME_DBG,
    PDSB_SOP_DPRIME_DBG,
    PDSB_SOP_OTHER
  } pdsb_sop_e;

  // One-cycle event strobes from transmitter, receiver and toggle engine
  typedef struct packed {
    logic tx_start_cmd;
    logic transmitter_on_cmd;
    logic hard_reset_send_cmd;
    logic soft_reset_failed;
    logic retries_exhausted;
    logic hard_reset_sent;
    logic packet_acked;
    logic soft_reset_received;
    logic hard_reset_received;
    logic ack_sent;
    logic overcurrent;
    logic overtemp;
    logic toggle_finished;
    logic rx_packet_stored;
  } pdsb_events_s;
endpackage : pdsb_pkg

// ---- tb/pdsb_bank_props.sv ----
// Port assertions for the PD status and interrupt bank.
// Assumes one clock and the bank's synchronous active-low reset.
`timescale 1ns/100ps
module pdsb_bank_props (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Engine side
  input wire pdsb_pkg::pdsb_events_s events_in,
  input wire pdsb_pkg::pdsb_sop_e rx_sop_type_in,
  input wire logic [2:0] toggle_result_code_in,
  input wire logic [1:0] internal_power_request_in,
  input wire logic [3:0] power_enables_in,
  input wire logic auto_soft_reset_enable_in,
  input wire logic [3:0] effective_power_out,
  input wire logic auto_soft_reset_req_out,
  input wire logic irq_pending_out
);
  import pdsb_pkg::*;
  logic [3:0] alt_pwr;
  logic rd_sa, rd_ts, rd_ea, rd_eb;
  // Host read decodes and the internal power value
  assign alt_pwr = {internal_power_request_in, power_enables_in[1:0]};
  assign rd_sa = reg_rd_in && (reg_addr_in == 8'h3C);
  assign rd_ts = reg_rd_in && (reg_addr_in == 8'h3D);
  assign rd_ea = reg_rd_in && (reg_addr_in == 8'h3E);
  assign rd_eb = reg_rd_in && (reg_addr_in == 8'h3F);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  AST_SOFT_FAIL:
    assert property (events_in.soft_reset_failed ##1 events_in == '0 ##1 rd_sa
      |=> reg_rdata_out[5]) else $error("Soft failure flag missing");
  AST_PWR_MIRROR:
    assert property (rd_sa |=> reg_rdata_out[3:2] == $past(internal_power_request_in))
    else $error("Power request not mirrored");
  AST_STATUS_RSV:
    assert property (rd_sa || rd_ts |=> reg_rdata_out[7:6] == 2'b00)
    else $error("Reserved status bits set");
  AST_TOGGLE:
    assert property (rd_ts |=> reg_rdata_out[5:3] == $past(toggle_result_code_in))
    else $error("Toggle code wrong");
  AST_EFF_PWR:
    assert property (1'b1 |=> effective_power_out == ($past(alt_pwr) >
      $past(power_enables_in) ? $past(alt_pwr) : $past(power_enables_in)))
    else $error("Effective power wrong");
  AST_AUTO_PULSE:
    assert property (events_in.retries_exhausted && auto_soft_reset_enable_in
      |=> auto_soft_reset_req_out ##1 !auto_soft_reset_req_out)
    else $error("Auto soft reset pulse wrong");
  AST_AUTO_CAUSE:
    assert property (auto_soft_reset_req_out
      |-> $past(events_in.retries_exhausted && auto_soft_reset_enable_in))
    else $error("Auto soft reset without cause");
  AST_IRQ_CLEAR:
    assert property (rd_ea && events_in == '0 ##1 events_in == '0 ##1 rd_ea
      |=> reg_rdata_out == 8'h00) else $error("Interrupts not cleared by read");
  AST_ACK_IRQ:
    assert property (events_in.ack_sent ##1 !reg_rd_in ##1 rd_eb
      |=> reg_rdata_out == 8'h01) else $error("Ack interrupt wrong");
  // Main scenarios reached
  cover property (rd_ea ##1 reg_rdata_out != 8'h00);
  cover property (auto_soft_reset_req_out);
  cover property (irq_pending_out ##1 !irq_pending_out);
endmodule : pdsb_bank_props

bind pdsb_bank pdsb_bank_props u_pdsb_bank_props (.clock_in, .rst_b_in, .reg_addr_in,
  .reg_rd_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .events_in, .rx_sop_type_in,
  .toggle_result_code_in, .internal_power_request_in, .power_enables_in,
  .auto_soft_reset_enable_in, .effective_power_out, .auto_soft_reset_req_out,
  .irq_pending_out);

// ---- tb/pdsb_engine_model.sv ----
// Model of the PD engines that strobe events into the bank.
// Assumes callers of send run between edges; lines change on falling edges.
`timescale 1ns/100ps
module pdsb_engine_model (
  // Clock
  input wire logic clock_in,
  // Strobes and packet type toward the bank
  output pdsb_pkg::pdsb_events_s events_out,
  output pdsb_pkg::pdsb_sop_e sop_type_out
);
  import pdsb_pkg::*;
  // Idle lines at time zero
  initial begin
    events_out = '0;
    sop_type_out = PDSB_SOP_OTHER;
  end
  // One-cycle strobe; the type line then shows a stale inverse
  task automatic send(input logic [13:0] ev, input pdsb_sop_e sop);
    @(negedge clock_in);
    events_out = pdsb_events_s'(ev);
    sop_type_out = sop;
    @(negedge clock_in);
    events_out = '0;
    sop_type_out = pdsb_sop_e'(~sop);
  endtask : send
endmodule : pdsb_engine_model

// ---- tb/test_pdsb_bank.sv ----
// Self-checking bench for the PD status and interrupt bank.
// Assumes the engine model drives strobes; the bench owns the register port.
`timescale 1ns/100ps
module test_pdsb_bank;
  import pdsb_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] tog = 3'h0;
  logic [1:0] ipr = 2'h0;
  logic [3:0] power_enables = 4'h0;
  logic auto_en = 1'b0;
  logic [7:0] rdata;
  logic [3:0] eff;
  logic asr, pend;
  pdsb_events_s ev;
  pdsb_sop_e sop;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int evb[8] = '{5, 6, 7, 8, 9, 10, 1, 3};
  logic [2:0] tc[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  pdsb_bank u_pdsb_bank (.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .events_in(ev), .rx_sop_type_in(sop), .toggle_result_code_in(tog),
    .internal_power_request_in(ipr), .power_enables_in(power_enables),
    .auto_soft_reset_enable_in(auto_en), .effective_power_out(eff),
    .auto_soft_reset_req_out(asr), .irq_pending_out(pend));
  pdsb_engine_model u_pdsb_engine_model (.clock_in(clock_in), .events_out(ev),
    .sop_type_out(sop));
  ////////////////////////////////////////
  // Clock and hang guard
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    addr = a;
    rd = 1'b1;
    @(negedge clock_in);
    rd = 1'b0;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd_chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock_in);
    wr = 1'b0;
  endtask : wr_reg
  task automatic pw_chk(input logic [3:0] p, input logic [1:0] q, input logic [7:0] exp);
    power_enables = p;
    ipr = q;
    repeat (2) @(negedge clock_in);
    chk("effective power", exp, {4'h0, eff});
  endtask : pw_chk
  task automatic final_report;
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (5) @(negedge clock_in);
    rst_b_in = 1'b1;
    for (int a = 8'h3C; a <= 8'h3F; a++) begin
      wr_reg(a[7:0], 8'hFF);
      rd_chk(a[7:0], 8'h00);
    end
    rd_chk(8'h50, 8'h00);
    wr_reg(8'h0E, 8'hA5);
    rd_chk(8'h0E, 8'hA5);
    wr_reg(8'h0F, 8'hFF);
    rd_chk(8'h0F, 8'h01);
    u_pdsb_engine_model.send(14'h0010, PDSB_SOP_OTHER);
    chk("irq pending", 8'h00, {7'h00, pend});
    rd_chk(8'h3F, 8'h01);
    rd_chk(8'h3F, 8'h00);
    wr_reg(8'h0F, 8'h00);
    wr_reg(8'h0E, 8'h80);
    u_pdsb_engine_model.send(14'h0008, PDSB_SOP_OTHER);
    chk("irq pending", 8'h00, {7'h00, pend});
    rd_chk(8'h3E, 8'h80);
    wr_reg(8'h0E, 8'h00);
    for (int i = 0; i < 8; i++) begin
      u_pdsb_engine_model.send(14'h1 << evb[i], PDSB_SOP_OTHER);
      chk("irq pending", 8'h01, {7'h00, pend});
      rd_chk(8'h3E, 8'h01 << i);
      rd_chk(8'h3E, 8'h00);
    end
    rd_chk(8'h3C, 8'h33);
    u_pdsb_engine_model.send(14'h0004, PDSB_SOP_OTHER);
    rd_chk(8'h3E, 8'h80);
    // Each transmit command clears the failure and received flags
    for (int c = 11; c <= 13; c++) begin
      u_pdsb_engine_model.send(14'h1 << c, PDSB_SOP_OTHER);
      rd_chk(8'h3C, 8'h00);
      u_pdsb_engine_model.send(14'h0660, PDSB_SOP_OTHER);
      rd_chk(8'h3C, 8'h33);
    end
    rd_chk(8'h3E, 8'h33);
    auto_en = 1'b1;
    u_pdsb_engine_model.send(14'h0200, PDSB_SOP_OTHER);
    chk("auto soft reset", 8'h01, {7'h00, asr});
    @(negedge clock_in);
    chk("auto soft reset", 8'h00, {7'h00, asr});
    auto_en = 1'b0;
    u_pdsb_engine_model.send(14'h0200, PDSB_SOP_OTHER);
    chk("auto soft reset", 8'h00, {7'h00, asr});
    rd_chk(8'h3E, 8'h10);
    // Event landing in the cycle of the clearing read survives it
    fork
      rd_chk(8'h3E, 8'h00);
      u_pdsb_engine_model.send(14'h0020, PDSB_SOP_OTHER);
    join
    rd_chk(8'h3E, 8'h01);
    for (int k = 0; k < 6; k++) begin
      tog = tc[k];
      u_pdsb_engine_model.send(14'h0001, pdsb_sop_e'(k % 4));
      rd_chk(8'h3D, {2'b00, tc[k], 3'((k % 4 == 3) ? 0 : 1 << (k % 4))});
    end
    pw_chk(4'h3, 2'b11, 8'h0F);
    pw_chk(4'h5, 2'b00, 8'h05);
    pw_chk(4'h1, 2'b10, 8'h09);
    rd_chk(8'h3C, 8'h3B);
    final_report();
  end
endmodule : test_pdsb_bank
